// File: core/fcc_pkg.sv
// frame checker counters: shared constants and types
package fcc_pkg;
    // widths and counts
    localparam int          NUM_ERR   = 8;
    localparam int          LIVE_W    = 16;
    localparam int          FRM_W     = 32;
    localparam int          REG_W     = 16;
    localparam int          BEAT_W    = 17;
    localparam int          FLD_BIT   = 0;
    // management register offsets
    localparam logic [15:0] ADR_TALLY   = 16'h0014;
    localparam logic [15:0] ADR_ENABLE  = 16'h9403;
    localparam logic [15:0] ADR_IRQ_EN  = 16'h9406;
    localparam logic [15:0] ADR_SRC_SEL = 16'h9407;
    localparam logic [15:0] ADR_MAX_LEN = 16'h9408;
    localparam logic [15:0] ADR_FRM_HI  = 16'h940a;
    localparam logic [15:0] ADR_FRM_LO  = 16'h940b;
    // snapshot offsets, in error vector order
    localparam logic [15:0] ERR_ADR [NUM_ERR] = '{16'h940c, 16'h940d, 16'h940e, 16'h940f,
                                                  16'h9410, 16'h9411, 16'h9412, 16'h9413};
    // error vector positions
    localparam int          E_LEN     = 0;
    localparam int          E_ALGN    = 1;
    localparam int          E_SYM     = 2;
    localparam int          E_OSZ     = 3;
    localparam int          E_USZ     = 4;
    localparam int          E_ODD     = 5;
    localparam int          E_ODDPRE  = 6;
    localparam int          E_DRIB    = 7;
    // reset values
    localparam logic [15:0] RST_MAX_LEN = 16'h05f2;
    localparam logic        RST_ENABLE  = 1'b1;
    localparam logic        RST_IRQ_EN  = 1'b1;
    localparam logic        RST_SRC_SEL = 1'b0;
    // frame constants
    localparam logic [15:0] MIN_LEN   = 16'h0040;
    localparam logic [3:0]  SFD_NIB   = 4'hd;
    localparam logic [7:0]  SFD_BYTE  = 8'hd5;

    typedef enum logic [1:0] {FCC_SPD_10, FCC_SPD_100, FCC_SPD_1000} fcc_speed_t;

    // one beat of a frame stream: nibble in data[3:0] at 10/100, byte at 1000
    typedef struct packed {
        logic       beat;
        logic       dv;
        logic       er;
        logic [7:0] data;
        logic       len_err;
        logic       algn_err;
        logic       dribble;
    } fcc_strm_t;

    // management register request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fcc_req_t;

    typedef logic [NUM_ERR-1:0] fcc_err_t;
endpackage

// File: core/fcc_counter.sv
// frame checker counters: live counter with latched snapshot
`timescale 1ns/10ps
module fcc_counter #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // events
    input  wire logic         inc,
    input  wire logic         latch,
    // values
    output logic [W-1:0] live,
    output logic [W-1:0] snap
);
    import fcc_pkg::*;

    logic [W-1:0] live_ff;
    logic [W-1:0] nxt_live;
    logic [W-1:0] snap_ff;
    logic [W-1:0] nxt_snap;

    // live count wraps; snapshot takes the value before this cycle's increment
    always_comb begin
        nxt_live = inc ? live_ff + 1'b1 : live_ff;
        nxt_snap = latch ? live_ff : snap_ff;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            live_ff <= '0;
            snap_ff <= '0;
        end else begin
            live_ff <= nxt_live;
            snap_ff <= nxt_snap;
        end
    end

    assign live = live_ff;
    assign snap = snap_ff;
endmodule

// File: core/fcc_src_mux.sv
// frame checker counters: source select and stream register
`timescale 1ns/10ps
module fcc_src_mux (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // streams in
    input  wire fcc_pkg::fcc_strm_t rx_strm,
    input  wire fcc_pkg::fcc_strm_t tx_strm,
    input  wire logic              sel_tx,
    // stream out
    output fcc_pkg::fcc_strm_t      strm
);
    import fcc_pkg::*;

    fcc_strm_t strm_ff;
    fcc_strm_t nxt_strm;

    // one register stage cuts the path from both MII sides
    always_comb begin
        nxt_strm = sel_tx ? tx_strm : rx_strm;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strm_ff <= '0;
        end else begin
            strm_ff <= nxt_strm;
        end
    end

    assign strm = strm_ff;
endmodule

// File: core/fcc_frame_checker.sv
// frame checker counters: frame monitor, registers and snapshots
`timescale 1ns/10ps
module fcc_frame_checker (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst,
    // management registers
    input  wire fcc_pkg::fcc_req_t  req,
    output logic [15:0]             rd_data,
    output logic                    rd_valid,
    output logic                    rd_hit,
    // frame streams
    input  wire fcc_pkg::fcc_strm_t rx_strm,
    input  wire fcc_pkg::fcc_strm_t tx_strm,
    input  wire fcc_pkg::fcc_speed_t speed,
    // event
    output logic                    checker_irq
);
    import fcc_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_BODY, ST_SKIP} fcc_state_t;

    fcc_strm_t         strm;
    logic              latch;
    logic              en_ff;
    logic              nxt_en;
    logic              irq_en_ff;
    logic              nxt_irq_en;
    logic              src_sel_ff;
    logic              nxt_src_sel;
    logic [REG_W-1:0]  max_len_ff;
    logic [REG_W-1:0]  nxt_max_len;
    fcc_state_t        state_ff;
    fcc_state_t        nxt_state;
    fcc_speed_t        spd_ff;
    fcc_speed_t        nxt_spd;
    logic [REG_W-1:0]  pre_cnt_ff;
    logic [REG_W-1:0]  nxt_pre_cnt;
    logic [BEAT_W-1:0] beat_cnt_ff;
    logic [BEAT_W-1:0] nxt_beat_cnt;
    logic              sym_ff;
    logic              nxt_sym;
    logic              lerr_ff;
    logic              nxt_lerr;
    logic              algn_ff;
    logic              nxt_algn;
    logic              drib_ff;
    logic              nxt_drib;
    logic              end_now;
    logic [REG_W-1:0]  len_now;
    logic              done_ff;
    logic              nxt_done;
    fcc_err_t          evt_ff;
    fcc_err_t          nxt_evt;
    logic [REG_W-1:0]  len_ff;
    logic [REG_W-1:0]  nxt_len;
    logic              irq_ff;
    logic              nxt_irq;
    logic [REG_W-1:0]  rd_data_ff;
    logic [REG_W-1:0]  nxt_rd_data;
    logic              rd_valid_ff;
    logic              nxt_rd_valid;
    logic              rd_hit_ff;
    logic              nxt_rd_hit;
    logic [FRM_W-1:0]  frm_live;
    logic [FRM_W-1:0]  frm_snap;
    logic [LIVE_W-1:0] err_live [NUM_ERR];
    logic [LIVE_W-1:0] err_snap [NUM_ERR];

    // gigabit carries bytes, the slower modes carry nibbles
    function automatic logic byte_mode(input fcc_speed_t s);
        return s == FCC_SPD_1000;
    endfunction

    function automatic logic is_sfd(input logic [7:0] d, input fcc_speed_t s);
        return byte_mode(s) ? (d == SFD_BYTE) : (d[3:0] == SFD_NIB);
    endfunction

    // byte length from beats after the delimiter, saturated at the register width
    function automatic logic [REG_W-1:0] beats_to_len(input logic [BEAT_W-1:0] c, input fcc_speed_t s);
        logic [BEAT_W-1:0] b;
        b = byte_mode(s) ? c : (c >> 1);
        return b[BEAT_W-1] ? '1 : b[REG_W-1:0];
    endfunction

    fcc_src_mux u_src (
        .core_clk (core_clk),
        .rst      (rst),
        .rx_strm  (rx_strm),
        .tx_strm  (tx_strm),
        .sel_tx   (src_sel_ff),
        .strm     (strm)
    );

    // a read of the tally register, wherever it is answered, snapshots all counts while the live counts keep running
    assign latch = req.rd && (req.addr == ADR_TALLY);

    // frame monitor
    always_comb begin
        nxt_state    = state_ff;
        nxt_spd      = spd_ff;
        nxt_pre_cnt  = pre_cnt_ff;
        nxt_beat_cnt = beat_cnt_ff;
        nxt_sym      = sym_ff;
        nxt_lerr     = lerr_ff;
        nxt_algn     = algn_ff;
        nxt_drib     = drib_ff;
        nxt_done     = 1'b0;
        nxt_evt      = evt_ff;
        nxt_len      = len_ff;
        end_now      = 1'b0;
        len_now      = beats_to_len(beat_cnt_ff, spd_ff);
        if (strm.beat) begin
            case (state_ff)
                ST_IDLE: begin
                    if (strm.dv && en_ff) begin
                        nxt_spd      = speed;
                        nxt_beat_cnt = '0;
                        nxt_sym      = strm.er;
                        nxt_lerr     = strm.len_err;
                        nxt_algn     = strm.algn_err;
                        nxt_drib     = strm.dribble;
                        if (is_sfd(strm.data, speed)) begin
                            nxt_pre_cnt = '0;
                            nxt_state   = ST_BODY;
                        end else begin
                            nxt_pre_cnt = {{(REG_W-1){1'b0}}, 1'b1};
                            nxt_state   = ST_PRE;
                        end
                    end else if (strm.dv) begin
                        nxt_state = ST_SKIP; // frames started while disabled are ignored whole
                    end
                end
                ST_PRE, ST_BODY: begin
                    nxt_lerr = lerr_ff | strm.len_err;
                    nxt_algn = algn_ff | strm.algn_err;
                    nxt_drib = drib_ff | strm.dribble;
                    if (!strm.dv) begin
                        end_now   = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_sym = sym_ff | strm.er;
                        if (state_ff == ST_PRE) begin
                            if (is_sfd(strm.data, spd_ff)) begin
                                nxt_state = ST_BODY;
                            end else if (!(&pre_cnt_ff)) begin
                                nxt_pre_cnt = pre_cnt_ff + 1'b1;
                            end
                        end else if (!(&beat_cnt_ff)) begin
                            nxt_beat_cnt = beat_cnt_ff + 1'b1;
                        end
                    end
                end
                ST_SKIP: begin
                    if (!strm.dv) begin
                        nxt_state = ST_IDLE;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
        // classify the frame on its last beat
        if (end_now) begin
            nxt_done         = 1'b1;
            nxt_len          = len_now;
            nxt_evt[E_LEN]   = nxt_lerr;
            nxt_evt[E_ALGN]  = nxt_algn;
            nxt_evt[E_SYM]   = sym_ff;
            nxt_evt[E_OSZ]   = len_now > max_len_ff;
            nxt_evt[E_USZ]   = len_now < MIN_LEN;
            nxt_evt[E_ODD]   = !byte_mode(spd_ff) && beat_cnt_ff[0];
            nxt_evt[E_ODDPRE] = (spd_ff == FCC_SPD_100) && pre_cnt_ff[0];
            nxt_evt[E_DRIB]  = (spd_ff == FCC_SPD_10) && nxt_drib;
        end
        nxt_irq = done_ff && (|evt_ff) && irq_en_ff;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff    <= ST_IDLE;
            spd_ff      <= FCC_SPD_10;
            pre_cnt_ff  <= '0;
            beat_cnt_ff <= '0;
            sym_ff      <= 1'b0;
            lerr_ff     <= 1'b0;
            algn_ff     <= 1'b0;
            drib_ff     <= 1'b0;
            done_ff     <= 1'b0;
            evt_ff      <= '0;
            len_ff      <= '0;
            irq_ff      <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            spd_ff      <= nxt_spd;
            pre_cnt_ff  <= nxt_pre_cnt;
            beat_cnt_ff <= nxt_beat_cnt;
            sym_ff      <= nxt_sym;
            lerr_ff     <= nxt_lerr;
            algn_ff     <= nxt_algn;
            drib_ff     <= nxt_drib;
            done_ff     <= nxt_done;
            evt_ff      <= nxt_evt;
            len_ff      <= nxt_len;
            irq_ff      <= nxt_irq;
        end
    end

    // counters: each counts on the cycle after the frame is classified
    fcc_counter #(.W(FRM_W)) u_frm (
        .core_clk (core_clk),
        .rst      (rst),
        .inc      (done_ff),
        .latch    (latch),
        .live     (frm_live),
        .snap     (frm_snap)
    );

    for (genvar g = 0; g < NUM_ERR; g++) begin : g_err
        fcc_counter #(.W(LIVE_W)) u_cnt (
            .core_clk (core_clk),
            .rst      (rst),
            .inc      (done_ff && evt_ff[g]),
            .latch    (latch),
            .live     (err_live[g]),
            .snap     (err_snap[g])
        );
    end

    // register writes and reads; read data stands until the next read
    always_comb begin
        nxt_en       = en_ff;
        nxt_irq_en   = irq_en_ff;
        nxt_src_sel  = src_sel_ff;
        nxt_max_len  = max_len_ff;
        nxt_rd_data  = rd_data_ff;
        nxt_rd_valid = req.rd;
        nxt_rd_hit   = 1'b0;
        if (req.wr) begin
            case (req.addr)
                ADR_ENABLE:  nxt_en      = req.wdata[FLD_BIT];
                ADR_IRQ_EN:  nxt_irq_en  = req.wdata[FLD_BIT];
                ADR_SRC_SEL: nxt_src_sel = req.wdata[FLD_BIT];
                ADR_MAX_LEN: nxt_max_len = req.wdata;
                default:     nxt_max_len = max_len_ff;
            endcase
        end
        if (req.rd) begin
            nxt_rd_data = '0;
            nxt_rd_hit  = 1'b1;
            case (req.addr)
                ADR_ENABLE:  nxt_rd_data[FLD_BIT] = en_ff;
                ADR_IRQ_EN:  nxt_rd_data[FLD_BIT] = irq_en_ff;
                ADR_SRC_SEL: nxt_rd_data[FLD_BIT] = src_sel_ff;
                ADR_MAX_LEN: nxt_rd_data = max_len_ff;
                ADR_FRM_HI:  nxt_rd_data = frm_snap[FRM_W-1:REG_W];
                ADR_FRM_LO:  nxt_rd_data = frm_snap[REG_W-1:0];
                default:     nxt_rd_hit  = 1'b0;
            endcase
            for (int i = 0; i < NUM_ERR; i++) begin
                if (req.addr == ERR_ADR[i]) begin
                    nxt_rd_data = err_snap[i];
                    nxt_rd_hit  = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_ff       <= RST_ENABLE;
            irq_en_ff   <= RST_IRQ_EN;
            src_sel_ff  <= RST_SRC_SEL;
            max_len_ff  <= RST_MAX_LEN;
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'b0;
            rd_hit_ff   <= 1'b0;
        end else begin
            en_ff       <= nxt_en;
            irq_en_ff   <= nxt_irq_en;
            src_sel_ff  <= nxt_src_sel;
            max_len_ff  <= nxt_max_len;
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
            rd_hit_ff   <= nxt_rd_hit;
        end
    end

    assign rd_data     = rd_data_ff;
    assign rd_valid    = rd_valid_ff;
    assign rd_hit      = rd_hit_ff;
    assign checker_irq = irq_ff;

    // checks
    max_len_wr_a: assert property (@(posedge core_clk) disable iff (rst)
        req.wr && req.addr == ADR_MAX_LEN |=> max_len_ff == $past(req.wdata))
        else $error("max frame limit not written");
    frm_latch_a: assert property (@(posedge core_clk) disable iff (rst)
        latch |=> frm_snap == $past(frm_live) && err_snap[E_SYM] == $past(err_live[E_SYM]))
        else $error("snapshot not taken on tally read");
    snap_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !latch |=> $stable(frm_snap) && $stable(err_snap[E_OSZ]))
        else $error("snapshot changed without latch");
    frm_count_a: assert property (@(posedge core_clk) disable iff (rst)
        done_ff |=> frm_live == $past(frm_live) + 1'b1)
        else $error("frame count did not advance");
    oversize_a: assert property (@(posedge core_clk) disable iff (rst)
        done_ff && $past(!(req.wr && req.addr == ADR_MAX_LEN)) |-> evt_ff[E_OSZ] == (len_ff > max_len_ff))
        else $error("oversize class wrong");
    undersize_a: assert property (@(posedge core_clk) disable iff (rst)
        done_ff |-> evt_ff[E_USZ] == (len_ff < MIN_LEN))
        else $error("undersize class wrong");
    odd_pre_a: assert property (@(posedge core_clk) disable iff (rst)
        done_ff && evt_ff[E_ODDPRE] |-> spd_ff == FCC_SPD_100)
        else $error("odd preamble outside 100 mode");
    dribble_a: assert property (@(posedge core_clk) disable iff (rst)
        done_ff && evt_ff[E_DRIB] |-> spd_ff == FCC_SPD_10)
        else $error("dribble outside 10 mode");
    odd_nib_a: assert property (@(posedge core_clk) disable iff (rst)
        done_ff && evt_ff[E_ODD] |-> spd_ff != FCC_SPD_1000)
        else $error("odd nibble in gigabit mode");
    irq_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        done_ff && (|evt_ff) && irq_en_ff |=> checker_irq ##1 !checker_irq)
        else $error("checker interrupt missing");
    disabled_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == ST_IDLE && strm.beat && strm.dv && !en_ff |=> state_ff == ST_SKIP)
        else $error("frame checked while disabled");
endmodule

// File: testbench/fcc_frame_src.sv
// frame source model: remote end and MAC transmit streams
`timescale 1ns/10ps
module fcc_frame_src (
    // clock
    input  wire logic           core_clk,
    // streams and line speed
    output fcc_pkg::fcc_strm_t  rx_strm,
    output fcc_pkg::fcc_strm_t  tx_strm,
    output fcc_pkg::fcc_speed_t speed
);
    import fcc_pkg::*;
    fcc_strm_t s     = '{beat: 1'b1, default: '0};
    fcc_strm_t idl;
    logic      on_tx = 1'b0;
    // quiet path shows inverted data so a stale beat never passes as a frame
    always_comb begin
        idl = s;
        idl.dv = 1'b0;
        idl.data = ~s.data;
        rx_strm = on_tx ? idl : s;
        tx_strm = on_tx ? s : idl;
    end
    initial speed = FCC_SPD_100;
    // preamble, delimiter, body, then one end beat with dv low
    task automatic send(input logic tx, input fcc_speed_t spd, input int np, input int nb,
                        input logic er, input logic le, input logic al, input logic dr);
        int   i;
        logic g;
        g = (spd == FCC_SPD_1000);
        @(posedge core_clk);
        on_tx <= tx;
        speed <= spd;
        for (i = 0; i <= np + nb + 1; i++) begin
            @(posedge core_clk);
            s.beat     <= 1'b1;
            s.dv       <= (i <= np + nb);
            s.data     <= (i < np) ? (g ? 8'h55 : 8'h05) :
                          (i == np) ? (g ? SFD_BYTE : {4'h0, SFD_NIB}) : 8'($urandom);
            // er outside dv is noise the checker must ignore
            s.er       <= (i == np + 1) ? er : (i > np + nb) ? 1'($urandom) : 1'b0;
            s.len_err  <= le && (i == np + 1);
            s.algn_err <= al && (i == np + 1);
            s.dribble  <= dr && (i > np + nb);
            // one stall cycle inside the body: garbage without beat must leave the frame intact
            if (i == np + 2) begin
                @(posedge core_clk);
                s.beat    <= 1'b0;
                s.dv      <= 1'b0;
                s.er      <= 1'b1;
                s.len_err <= 1'b1;
            end
        end
    endtask
endmodule

// File: testbench/fcc_frame_checker_bench.sv
// frame checker counters: self-checking bench
`timescale 1ns/10ps
module fcc_frame_checker_bench;
    import fcc_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    fcc_req_t    req      = '0;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        rd_hit;
    logic        checker_irq;
    fcc_strm_t   rx_strm;
    fcc_strm_t   tx_strm;
    fcc_speed_t  speed;
    int          err_count = 0;
    int          cmp_count = 0;
    int          irq_seen  = 0;
    int          irq_exp   = 0;
    int          k;
    logic [15:0] lim       = RST_MAX_LEN;
    logic        en        = 1'b1;
    logic        sel       = 1'b0;
    logic        ien       = 1'b1;
    logic [15:0] live [NUM_ERR] = '{default: '0};
    logic [15:0] snap [NUM_ERR] = '{default: '0};
    logic [31:0] frm_live  = '0;
    logic [31:0] frm_snap  = '0;
    logic [15:0] d;
    logic        h;

    always #12.5 core_clk = ~core_clk;

    fcc_frame_checker dut (.core_clk(core_clk), .rst(rst), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_hit(rd_hit), .rx_strm(rx_strm), .tx_strm(tx_strm),
        .speed(speed), .checker_irq(checker_irq));
    fcc_frame_src src (.core_clk(core_clk), .rx_strm(rx_strm), .tx_strm(tx_strm), .speed(speed));

    // interrupt pulses are tallied here and compared at the end
    // sampled mid-cycle so the pulse is seen once, well away from its launching edge
    always @(negedge core_clk) if (checker_irq === 1'b1) irq_seen++;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // one read: the answer comes exactly one cycle later and lasts one cycle, data stays
    task automatic rd(input logic [15:0] a);
        @(posedge core_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1;
        check("rd_valid", rd_valid, 1);
        h = rd_hit;
        d = rd_data;
        @(posedge core_clk);
        #1;
        check("rd_valid low", rd_valid, 0);
        check("rd_data hold", rd_data, d);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge core_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= v;
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rchk(input string n, input logic [15:0] a, input logic [15:0] e, input logic eh);
        rd(a);
        check(n, d, e);
        check("hit", h, eh);
    endtask

    // tally read copies every live count at once
    task automatic latch;
        rd(ADR_TALLY);
        check("tally hit", h, 0);
        frm_snap = frm_live;
        snap = live;
    endtask

    task automatic snaps;
        rchk("frames hi", ADR_FRM_HI, frm_snap[31:16], 1);
        rchk("frames lo", ADR_FRM_LO, frm_snap[15:0], 1);
        for (k = 0; k < NUM_ERR; k++) rchk("error snap", ERR_ADR[k], snap[k], 1);
    endtask

    function automatic fcc_err_t classify(fcc_speed_t s, int np, int nb, logic er, logic le,
                                          logic al, logic dr);
        fcc_err_t e;
        int       len;
        len = (s == FCC_SPD_1000) ? nb : nb / 2;
        e[E_LEN]    = le;
        e[E_ALGN]   = al;
        e[E_SYM]    = er;
        e[E_OSZ]    = len > int'(lim);
        e[E_USZ]    = len < 64;
        e[E_ODD]    = s != FCC_SPD_1000 && nb[0];
        e[E_ODDPRE] = s == FCC_SPD_100 && np[0];
        e[E_DRIB]   = s == FCC_SPD_10 && dr;
        return e;
    endfunction

    // send one frame and book what the checker should make of it
    task automatic frame(input logic tx, input fcc_speed_t s, input int np, input int nb,
                         input logic er, input logic le, input logic al, input logic dr);
        fcc_err_t e;
        src.send(tx, s, np, nb, er, le, al, dr);
        repeat (6) @(posedge core_clk);
        e = classify(s, np, nb, er, le, al, dr);
        if (en && tx == sel) begin
            frm_live++;
            for (k = 0; k < NUM_ERR; k++) live[k] += 16'(e[k]);
            if (ien && |e) irq_exp++;
        end
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'hc9f862cf));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rchk("limit", ADR_MAX_LEN, 16'h05f2, 1);
        rchk("enable", ADR_ENABLE, 16'h0001, 1);
        rchk("source", ADR_SRC_SEL, 16'h0000, 1);
        rchk("irq enable", ADR_IRQ_EN, 16'h0001, 1);
        rchk("unmapped", 16'h9409, 16'h0000, 0);
        snaps();
        // length boundaries against the reset limit and the 64 byte floor
        frame(0, FCC_SPD_1000, 7, 1522, 0, 0, 0, 0);
        frame(0, FCC_SPD_1000, 7, 1523, 0, 0, 0, 0);
        frame(0, FCC_SPD_100, 14, 128, 0, 0, 0, 0);
        frame(0, FCC_SPD_100, 15, 127, 1, 0, 0, 1);
        frame(0, FCC_SPD_10, 15, 129, 0, 1, 0, 1);
        frame(0, FCC_SPD_1000, 7, 63, 0, 0, 1, 1);
        latch();
        snaps();
        // snapshots hold while live counts move, and refuse writes
        frame(0, FCC_SPD_100, 14, 100, 1, 1, 1, 0);
        wr(ERR_ADR[E_LEN], 16'hffff);
        snaps();
        latch();
        snaps();
        // disabled checker, then the other source
        wr(ADR_ENABLE, 16'h0000);
        en = 1'b0;
        frame(0, FCC_SPD_100, 14, 90, 1, 1, 0, 0);
        wr(ADR_ENABLE, 16'h0001);
        en = 1'b1;
        wr(ADR_SRC_SEL, 16'h0001);
        sel = 1'b1;
        rchk("source", ADR_SRC_SEL, 16'h0001, 1);
        frame(0, FCC_SPD_100, 14, 90, 1, 0, 0, 0);
        frame(1, FCC_SPD_100, 14, 90, 1, 0, 0, 0);
        wr(ADR_IRQ_EN, 16'h0000);
        ien = 1'b0;
        frame(1, FCC_SPD_10, 14, 91, 0, 1, 0, 0);
        wr(ADR_IRQ_EN, 16'h0001);
        ien = 1'b1;
        // random traffic against a small limit
        lim = 16'h0040 + 16'($urandom % 16);
        wr(ADR_MAX_LEN, lim);
        rchk("limit", ADR_MAX_LEN, lim, 1);
        repeat (24) frame(1'($urandom), fcc_speed_t'($urandom % 3), 2 + $urandom % 14,
                          100 + $urandom % 60, 1'($urandom), 1'($urandom), 1'($urandom),
                          1'($urandom));
        latch();
        snaps();
        check("irq pulses", irq_seen, irq_exp);
        end_of_test();
    end
endmodule
